//--- core/media_cfg_ctrl.sv
/*
 * Host-side controller that plays the media port and general-purpose pin
 * programming sequences into the device as single register writes.
 * Assumes the device answers each held write strobe with a one-cycle ack.
 */
`timescale 1ns/100ps
module media_cfg_ctrl (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Device register write port
   output logic             DEV_STB,
   output logic      [3:0]  DEV_ADDR,
   output logic      [31:0] DEV_WDATA,
   input  wire logic        DEV_ACK
);

   // Register file side
   logic                      cmd_pulse;
   logic [3:0]                cmd_code;
   logic [31:0]               opbase;
   logic [31:0]               gpbase;
   logic                      refused_clr;
   logic [31:0]               status_word;

   // Command decode
   logic                      cmd_is_port;
   logic                      cmd_is_gp;
   logic                      accept;
   logic                      refuse;

   // Sequencer
   media_cfg_pkg::seq_state_t state_reg;
   media_cfg_pkg::seq_state_t state_next;
   media_cfg_pkg::cmd_t       cur_reg;
   media_cfg_pkg::cmd_t       load_cmd;
   logic [2:0]                step_reg;
   logic [2:0]                load_step;
   logic [2:0]                last_step;
   logic [35:0]               load_word;
   logic                      cur_is_gp;
   logic                      cur_is_aui;
   logic                      cur_is_mii;
   logic                      seq_done;

   // Status flags
   logic                      busy_reg;
   logic                      port_done_reg;
   logic                      refused_reg;

   // Device write port
   logic                      dev_stb_reg;
   logic [3:0]                dev_addr_reg;
   logic [31:0]               dev_wdata_reg;

   media_cfg_wb_regs media_cfg_wb_regs_inst (
      .clk         (SYS_CLK),
      .rst_n       (RST_N),
      .wb_cyc      (WB_CYC_I),
      .wb_stb      (WB_STB_I),
      .wb_we       (WB_WE_I),
      .wb_adr      (WB_ADR_I),
      .wb_sel      (WB_SEL_I),
      .wb_dat_i    (WB_DAT_I),
      .wb_dat_o    (WB_DAT_O),
      .wb_ack      (WB_ACK_O),
      .cmd_pulse   (cmd_pulse),
      .cmd_code    (cmd_code),
      .opbase      (opbase),
      .gpbase      (gpbase),
      .refused_clr (refused_clr),
      .status_word (status_word)
   );

   // Port selection only once after reset, pin commands any time when idle
   assign cmd_is_port = (cmd_code >= media_cfg_pkg::CMD_MII_HD) &&
                        (cmd_code <= media_cfg_pkg::CMD_AUI_2);
   assign cmd_is_gp   = (cmd_code >= media_cfg_pkg::CMD_GP_IRQ) &&
                        (cmd_code <= media_cfg_pkg::CMD_GP_LED);
   assign accept      = cmd_pulse && !busy_reg &&
                        (cmd_is_gp || (cmd_is_port && !port_done_reg));
   assign refuse      = cmd_pulse && !accept;

   // Address and data of one step of a sequence
   function automatic logic [35:0] step_word(
      input media_cfg_pkg::cmd_t c,
      input logic [2:0]          s,
      input logic [31:0]         opb,
      input logic [31:0]         gpb
   );
      logic        fdx;
      logic        symbol_port;
      logic        tp;
      logic        aui;
      logic        gp;
      logic [31:0] op_clr;
      logic [31:0] op_first;
      logic [31:0] op_final;
      logic [31:0] gp_hold;
      logic [31:0] gp_aui;
      logic [31:0] role;
      logic [31:0] txrx;
      logic [35:0] w;
      fdx      = (c == media_cfg_pkg::CMD_MII_FD) || (c == media_cfg_pkg::CMD_SYM_FD) ||
                 (c == media_cfg_pkg::CMD_TP_FD);
      symbol_port      = (c == media_cfg_pkg::CMD_SYM_HD) || (c == media_cfg_pkg::CMD_SYM_FD);
      tp       = (c == media_cfg_pkg::CMD_TP_HD) || (c == media_cfg_pkg::CMD_TP_FD) ||
                 (c == media_cfg_pkg::CMD_TP_AN);
      aui      = (c == media_cfg_pkg::CMD_AUI_5) || (c == media_cfg_pkg::CMD_AUI_2);
      gp       = (c >= media_cfg_pkg::CMD_GP_IRQ) && (c <= media_cfg_pkg::CMD_GP_LED);
      op_clr   = opb & media_cfg_pkg::OP_KEEP;
      op_first = op_clr;
      if (tp && fdx) begin
         op_first = op_clr | (media_cfg_pkg::ONE << media_cfg_pkg::B_FDX);
      end
      op_final = op_clr | (media_cfg_pkg::ONE << media_cfg_pkg::B_PORTSEL);
      if (fdx) begin
         op_final = op_final | (media_cfg_pkg::ONE << media_cfg_pkg::B_FDX);
      end
      if (symbol_port) begin
         op_final = op_final | (media_cfg_pkg::ONE << media_cfg_pkg::B_SYM_A) |
                    (media_cfg_pkg::ONE << media_cfg_pkg::B_SYM_B);
      end
      gp_hold  = gpb & (media_cfg_pkg::GP_KEEP |
                        (media_cfg_pkg::ONE << media_cfg_pkg::B_AUI_5));
      gp_aui   = gpb & media_cfg_pkg::GP_KEEP;
      if (c == media_cfg_pkg::CMD_AUI_5) begin
         gp_aui = gp_aui | (media_cfg_pkg::ONE << media_cfg_pkg::B_AUI_5);
      end
      // One role bit per pin command, none for CMD_GP_IN
      case (c)
         media_cfg_pkg::CMD_GP_IRQ: role = media_cfg_pkg::ONE << media_cfg_pkg::B_GP_IRQ;
         media_cfg_pkg::CMD_GP_OUT: role = media_cfg_pkg::ONE << media_cfg_pkg::B_GP_OUT;
         media_cfg_pkg::CMD_GP_LED: role = media_cfg_pkg::ONE << media_cfg_pkg::B_GP_LED;
         default:                   role = 32'h0000_0000;
      endcase
      case (c)
         media_cfg_pkg::CMD_TP_HD:  txrx = media_cfg_pkg::TXRX_TP_HD;
         media_cfg_pkg::CMD_TP_FD:  txrx = media_cfg_pkg::TXRX_TP_FD;
         media_cfg_pkg::CMD_TP_AN:  txrx = media_cfg_pkg::TXRX_AN;
         media_cfg_pkg::CMD_AUI_5:  txrx = media_cfg_pkg::TXRX_AUI;
         media_cfg_pkg::CMD_AUI_2:  txrx = media_cfg_pkg::TXRX_AUI;
         default:                   txrx = media_cfg_pkg::TXRX_OFF;
      endcase
      w = {media_cfg_pkg::DEV_OPMODE, op_clr};
      if (gp) begin
         // Latch write first, then the same word with the latch bit clear
         if (s == media_cfg_pkg::STEP_FIRST) begin
            w = {media_cfg_pkg::DEV_GP,
                 gp_hold | role | (media_cfg_pkg::ONE << media_cfg_pkg::B_GP_LATCH)};
         end else begin
            w = {media_cfg_pkg::DEV_GP, gp_hold | role};
         end
      end else begin
         case (s)
            media_cfg_pkg::STEP_FIRST: w = {media_cfg_pkg::DEV_OPMODE, op_first};
            media_cfg_pkg::STEP_CONN0: w = {media_cfg_pkg::DEV_CONN, media_cfg_pkg::CONN_OFF};
            media_cfg_pkg::STEP_TXRX:  w = {media_cfg_pkg::DEV_TXRX, txrx};
            media_cfg_pkg::STEP_FINAL: begin
               if (aui) begin
                  w = {media_cfg_pkg::DEV_GP, gp_aui};
               end else if (tp) begin
                  w = {media_cfg_pkg::DEV_CONN, media_cfg_pkg::CONN_TP};
               end else begin
                  w = {media_cfg_pkg::DEV_OPMODE, op_final};
               end
            end
            media_cfg_pkg::STEP_LAST5: w = {media_cfg_pkg::DEV_CONN, media_cfg_pkg::CONN_AUI};
            default:                   w = {media_cfg_pkg::DEV_OPMODE, op_clr};
         endcase
      end
      return w;
   endfunction : step_word

   // Family of the command being played
   assign cur_is_gp  = (cur_reg >= media_cfg_pkg::CMD_GP_IRQ) &&
                       (cur_reg <= media_cfg_pkg::CMD_GP_LED);
   assign cur_is_aui = (cur_reg == media_cfg_pkg::CMD_AUI_5) ||
                       (cur_reg == media_cfg_pkg::CMD_AUI_2);
   assign cur_is_mii = (cur_reg >= media_cfg_pkg::CMD_MII_HD) &&
                       (cur_reg <= media_cfg_pkg::CMD_SYM_FD);

   // Last step index of the command being played
   always_comb begin
      if (cur_is_gp) begin
         last_step = 3'(media_cfg_pkg::STEPS_GP - 3'h1);
      end else if (cur_is_aui) begin
         last_step = 3'(media_cfg_pkg::STEPS_PORT5 - 3'h1);
      end else begin
         last_step = 3'(media_cfg_pkg::STEPS_PORT4 - 3'h1);
      end
   end

   assign seq_done = (state_reg == media_cfg_pkg::SEQ_GAP) && (step_reg == last_step);

   // Word for the next device write
   always_comb begin
      if (state_reg == media_cfg_pkg::SEQ_IDLE) begin
         load_cmd  = media_cfg_pkg::cmd_t'(cmd_code);
         load_step = media_cfg_pkg::STEP_FIRST;
      end else begin
         load_cmd  = cur_reg;
         load_step = 3'(step_reg + 3'h1);
      end
      load_word = step_word(load_cmd, load_step, opbase, gpbase);
   end

   // One write per step, a gap cycle between writes
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         media_cfg_pkg::SEQ_IDLE: begin
            if (accept) begin
               state_next = media_cfg_pkg::SEQ_DRIVE;
            end
         end
         media_cfg_pkg::SEQ_DRIVE: begin
            if (DEV_ACK) begin
               state_next = media_cfg_pkg::SEQ_GAP;
            end
         end
         media_cfg_pkg::SEQ_GAP: begin
            if (step_reg == last_step) begin
               state_next = media_cfg_pkg::SEQ_IDLE;
            end else begin
               state_next = media_cfg_pkg::SEQ_DRIVE;
            end
         end
         default: state_next = media_cfg_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= media_cfg_pkg::SEQ_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cur_reg <= media_cfg_pkg::CMD_NONE;
      end else if (accept) begin
         cur_reg <= media_cfg_pkg::cmd_t'(cmd_code);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         step_reg <= media_cfg_pkg::STEP_FIRST;
      end else if (accept) begin
         step_reg <= media_cfg_pkg::STEP_FIRST;
      end else if ((state_reg == media_cfg_pkg::SEQ_GAP) && !seq_done) begin
         step_reg <= 3'(step_reg + 3'h1);
      end
   end

   // Strobe held with address and data until the device acknowledges
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         dev_stb_reg   <= 1'b0;
         dev_addr_reg  <= 4'h0;
         dev_wdata_reg <= 32'h0000_0000;
      end else begin
         dev_stb_reg <= (state_next == media_cfg_pkg::SEQ_DRIVE);
         if ((state_reg != media_cfg_pkg::SEQ_DRIVE) &&
             (state_next == media_cfg_pkg::SEQ_DRIVE)) begin
            dev_addr_reg  <= load_word[35:32];
            dev_wdata_reg <= load_word[31:0];
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         busy_reg <= 1'b0;
      end else if (accept) begin
         busy_reg <= 1'b1;
      end else if (seq_done) begin
         busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         port_done_reg <= 1'b0;
      end else if (seq_done && !cur_is_gp) begin
         port_done_reg <= 1'b1;
      end
   end

   // Sticky refusal, a new refusal wins over a clear
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         refused_reg <= 1'b0;
      end else if (refuse) begin
         refused_reg <= 1'b1;
      end else if (refused_clr) begin
         refused_reg <= 1'b0;
      end
   end

   always_comb begin
      status_word                              = 32'h0000_0000;
      status_word[media_cfg_pkg::ST_BUSY]     = busy_reg;
      status_word[media_cfg_pkg::ST_PORTDONE] = port_done_reg;
      status_word[media_cfg_pkg::ST_REFUSED]  = refused_reg;
   end

   assign DEV_STB   = dev_stb_reg;
   assign DEV_ADDR  = dev_addr_reg;
   assign DEV_WDATA = dev_wdata_reg;

   // Checks on the device write port and on the refusal of a second port selection
   default clocking cb_sys @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_dev_wait;
      DEV_STB && !DEV_ACK;
   endsequence

   sequence s_dev_taken;
      DEV_STB && DEV_ACK;
   endsequence

   sequence s_gp_latch_taken;
      DEV_STB && DEV_ACK && (DEV_ADDR == media_cfg_pkg::DEV_GP) &&
      DEV_WDATA[media_cfg_pkg::B_GP_LATCH];
   endsequence

   sequence s_gp_release;
      !DEV_STB ##1 (DEV_STB && (DEV_ADDR == media_cfg_pkg::DEV_GP) &&
                    !DEV_WDATA[media_cfg_pkg::B_GP_LATCH]);
   endsequence

   sequence s_mii_txrx_taken;
      DEV_STB && DEV_ACK && cur_is_mii && (DEV_ADDR == media_cfg_pkg::DEV_TXRX);
   endsequence

   sequence s_mii_final;
      !DEV_STB ##1 (DEV_STB && (DEV_ADDR == media_cfg_pkg::DEV_OPMODE) &&
                    DEV_WDATA[media_cfg_pkg::B_PORTSEL]);
   endsequence

   a_stb_held: assert property (s_dev_wait |=>
      DEV_STB && $stable(DEV_ADDR) && $stable(DEV_WDATA))
      else $error("Device write changed before it was acknowledged");

   a_stb_release: assert property (s_dev_taken |=> !DEV_STB)
      else $error("Device strobe still high after the acknowledge");

   a_gp_pair: assert property (s_gp_latch_taken |=> s_gp_release)
      else $error("Pin latch write not followed by its release write");

   a_one_role: assert property ((DEV_STB && (DEV_ADDR == media_cfg_pkg::DEV_GP) &&
      DEV_WDATA[media_cfg_pkg::B_GP_LATCH]) |-> $onehot0({DEV_WDATA[media_cfg_pkg::B_GP_IRQ],
      DEV_WDATA[media_cfg_pkg::B_GP_LED], DEV_WDATA[media_cfg_pkg::B_GP_OUT]}))
      else $error("Pin latch write selects more than one role");

   a_port_first: assert property ((accept && cmd_is_port) |=> DEV_STB &&
      (DEV_ADDR == media_cfg_pkg::DEV_OPMODE) && !DEV_WDATA[media_cfg_pkg::B_PORTSEL])
      else $error("Port sequence did not open by clearing port select");

   a_mii_final: assert property (s_mii_txrx_taken |=> s_mii_final)
      else $error("Port select not set right after the tx/rx write");

   a_port_once: assert property ((cmd_pulse && cmd_is_port && port_done_reg) |=>
      refused_reg && (cur_reg == $past(cur_reg)))
      else $error("Second port selection was not refused");

endmodule : media_cfg_ctrl

//--- core/media_cfg_pkg.sv
/*
 * Constants, command codes and bit positions for the media port and
 * general-purpose pin configuration controller.
 * Assumes the device takes one 32-bit register write per strobe/ack pair.
 */
package media_cfg_pkg;

   // Own register map, byte offsets
   localparam logic [3:0]  WB_CMD      = 4'h0;
   localparam logic [3:0]  WB_OPBASE   = 4'h4;
   localparam logic [3:0]  WB_GPBASE   = 4'h8;
   localparam logic [3:0]  WB_STATUS   = 4'hC;
   localparam int          ST_BUSY     = 0;
   localparam int          ST_PORTDONE = 1;
   localparam int          ST_REFUSED  = 2;

   // Device register indices
   localparam logic [3:0]  DEV_OPMODE  = 4'h6;
   localparam logic [3:0]  DEV_CONN    = 4'hD;
   localparam logic [3:0]  DEV_TXRX    = 4'hE;
   localparam logic [3:0]  DEV_GP      = 4'hF;

   // Operating mode bits
   localparam int          B_PORTSEL   = 18;
   localparam int          B_FDX       = 9;
   localparam int          B_SYM_A     = 23;
   localparam int          B_SYM_B     = 24;
   // General port bits
   localparam int          B_GP_LATCH  = 27;
   localparam int          B_GP_IRQ    = 25;
   localparam int          B_GP_LED    = 21;
   localparam int          B_GP_OUT    = 17;
   localparam int          B_AUI_5     = 3;

   localparam logic [31:0] ONE         = 32'h0000_0001;
   localparam logic [31:0] OP_KEEP     = ~((ONE << B_PORTSEL) | (ONE << B_FDX) |
                                           (ONE << B_SYM_A) | (ONE << B_SYM_B));
   localparam logic [31:0] GP_KEEP     = ~((ONE << B_GP_LATCH) | (ONE << B_GP_IRQ) |
                                           (ONE << B_GP_LED) | (ONE << B_GP_OUT) |
                                           (ONE << B_AUI_5));

   // Device data values
   localparam logic [31:0] CONN_OFF    = 32'h0000_0000;
   localparam logic [31:0] CONN_TP     = 32'h0000_0001;
   localparam logic [31:0] CONN_AUI    = 32'h0000_0009;
   localparam logic [31:0] TXRX_OFF    = 32'h0000_0000;
   localparam logic [31:0] TXRX_TP_HD  = 32'h0000_7F3F;
   localparam logic [31:0] TXRX_TP_FD  = 32'h0000_7F3D;
   localparam logic [31:0] TXRX_AN     = 32'h0003_FFFF;
   localparam logic [31:0] TXRX_AUI    = 32'h0000_0705;

   typedef enum logic [3:0] {
      CMD_NONE   = 4'h0,
      CMD_MII_HD = 4'h1,
      CMD_MII_FD = 4'h2,
      CMD_SYM_HD = 4'h3,
      CMD_SYM_FD = 4'h4,
      CMD_TP_HD  = 4'h5,
      CMD_TP_FD  = 4'h6,
      CMD_TP_AN  = 4'h7,
      CMD_AUI_5  = 4'h8,
      CMD_AUI_2  = 4'h9,
      CMD_GP_IRQ = 4'hA,
      CMD_GP_IN  = 4'hB,
      CMD_GP_OUT = 4'hC,
      CMD_GP_LED = 4'hD
   } cmd_t;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_DRIVE = 2'b01,
      SEQ_GAP   = 2'b10
   } seq_state_t;

   localparam logic [2:0]  STEP_FIRST  = 3'h0;
   localparam logic [2:0]  STEPS_PORT4 = 3'h4;
   localparam logic [2:0]  STEPS_PORT5 = 3'h5;
   localparam logic [2:0]  STEPS_GP    = 3'h2;
   localparam logic [2:0]  STEP_CONN0  = 3'h1;
   localparam logic [2:0]  STEP_TXRX   = 3'h2;
   localparam logic [2:0]  STEP_FINAL  = 3'h3;
   localparam logic [2:0]  STEP_LAST5  = 3'h4;

endpackage : media_cfg_pkg

//--- core/media_cfg_wb_regs.sv
/*
 * Classic Wishbone slave holding the controller's own registers.
 * Assumes a master that holds each request until it samples ack.
 */
`timescale 1ns/100ps
module media_cfg_wb_regs (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Wishbone slave
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [3:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack,
   // Register contents
   output logic             cmd_pulse,
   output logic      [3:0]  cmd_code,
   output logic      [31:0] opbase,
   output logic      [31:0] gpbase,
   output logic             refused_clr,
   input  wire logic [31:0] status_word
);

   logic        ack_reg;
   logic        wr_hit;
   logic [31:0] rd_next;
   logic [31:0] rd_reg;
   logic [31:0] opbase_reg;
   logic [31:0] gpbase_reg;
   logic        cmd_pulse_reg;
   logic [3:0]  cmd_code_reg;
   logic        refused_clr_reg;

   assign wr_hit = wb_cyc && wb_stb && wb_we && !ack_reg;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_cyc && wb_stb && !ack_reg;
      end
   end

   // Byte-lane writes of the base registers
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               opbase_reg[8*b +: 8] <= 8'h00;
               gpbase_reg[8*b +: 8] <= 8'h00;
            end else if (wr_hit && wb_sel[b]) begin
               if (wb_adr == media_cfg_pkg::WB_OPBASE) begin
                  opbase_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
               end
               if (wb_adr == media_cfg_pkg::WB_GPBASE) begin
                  gpbase_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
               end
            end
         end
      end
   endgenerate

   // Command launch and status clear pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_pulse_reg   <= 1'b0;
         cmd_code_reg    <= 4'h0;
         refused_clr_reg <= 1'b0;
      end else begin
         cmd_pulse_reg   <= wr_hit && wb_sel[0] && (wb_adr == media_cfg_pkg::WB_CMD);
         refused_clr_reg <= wr_hit && wb_sel[0] && (wb_adr == media_cfg_pkg::WB_STATUS) &&
                            wb_dat_i[media_cfg_pkg::ST_REFUSED];
         if (wr_hit && wb_sel[0] && (wb_adr == media_cfg_pkg::WB_CMD)) begin
            cmd_code_reg <= wb_dat_i[3:0];
         end
      end
   end

   always_comb begin
      case (wb_adr)
         media_cfg_pkg::WB_CMD:    rd_next = {28'h0000000, cmd_code_reg};
         media_cfg_pkg::WB_OPBASE: rd_next = opbase_reg;
         media_cfg_pkg::WB_GPBASE: rd_next = gpbase_reg;
         media_cfg_pkg::WB_STATUS: rd_next = status_word;
         default:                  rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_reg <= 32'h0000_0000;
      end else if (wb_cyc && wb_stb && !ack_reg) begin
         rd_reg <= rd_next;
      end
   end

   assign wb_ack      = ack_reg;
   assign wb_dat_o    = rd_reg;
   assign cmd_pulse   = cmd_pulse_reg;
   assign cmd_code    = cmd_code_reg;
   assign opbase      = opbase_reg;
   assign gpbase      = gpbase_reg;
   assign refused_clr = refused_clr_reg;

endmodule : media_cfg_wb_regs

//--- verif/dev_model.sv
/*
 * Behavioural device: four write-only registers and the pin role latch.
 * Assumes a held DEV_STB until one-cycle ack; lat sets the answer delay.
 */
`timescale 1ns/100ps
module dev_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register write port
   input  wire logic        stb,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic [1:0]  lat,
   output logic             ack,
   // Observed state
   output logic      [31:0] op,
   output logic      [31:0] conn,
   output logic      [31:0] txrx,
   output logic      [31:0] gp,
   output logic      [1:0]  role,
   output logic      [7:0]  nwr
);
   logic [1:0] wait_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ack, wait_reg, op, conn, txrx, gp, role, nwr} <= '0;
      end else begin
         ack <= 1'b0;
         if (stb && !ack && wait_reg == lat) begin
            ack <= 1'b1;
            wait_reg <= 2'h0;
            nwr <= nwr + 8'h1;
            case (addr)
               media_cfg_pkg::DEV_OPMODE: op <= wdata;
               media_cfg_pkg::DEV_CONN: conn <= wdata;
               media_cfg_pkg::DEV_TXRX: txrx <= wdata;
               media_cfg_pkg::DEV_GP: begin
                  gp <= wdata;
                  if (wdata[27])  // One role, taken only with the latch bit
                     role <= wdata[21] ? 2'h3 : wdata[17] ? 2'h2 : wdata[25] ? 2'h0 : 2'h1;
               end
               default: ;
            endcase
         end else if (stb && !ack) begin
            wait_reg <= wait_reg + 2'h1;
         end
      end
   end
endmodule : dev_model

//--- verif/tb_top.sv
/*
 * Testbench: every port and pin command through Wishbone, device modelled.
 * Assumes status busy bit clears when a sequence is finished.
 */
`timescale 1ns/100ps
module tb_top;
   logic clk, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, dstb, dack;
   logic [3:0] adr = 0, dadr;
   logic [31:0] wdat = 0, rdat, dwd, op, conn, txrx, gp, r, lf = 32'h40D6;
   logic [1:0] lat = 0, role;
   logic [7:0] nwr;
   int mismatches = 0, total_checks = 0;
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   media_cfg_ctrl media_cfg_ctrl_inst (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .DEV_STB(dstb), .DEV_ADDR(dadr), .DEV_WDATA(dwd),
      .DEV_ACK(dack));
   dev_model dev_model_inst (.clk(clk), .rst_n(rst_n), .stb(dstb), .addr(dadr), .wdata(dwd),
      .lat(lat), .ack(dack), .op(op), .conn(conn), .txrx(txrx), .gp(gp), .role(role), .nwr(nwr));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 200);
      if (n >= 200) begin
         mismatches++;
         end_of_test();
      end
      r = rdat;
      {cyc, stb, we} <= 3'b000;
   endtask : wb
   task run(input logic [3:0] c);
      int n;
      wb(1'b1, media_cfg_pkg::WB_CMD, {28'h0, c});
      for (n = 0; n < 50; n++) begin
         wb(1'b0, media_cfg_pkg::WB_STATUS, 32'h0);
         if (r[media_cfg_pkg::ST_BUSY] === 1'b0) break;
      end
      if (n == 50) begin
         mismatches++;
         end_of_test();
      end
   endtask : run
   initial begin
      logic [31:0] ec, et;
      logic [3:0] eo;
      logic [7:0] nw;
      repeat (5) @(posedge clk);
      for (int c = 1; c < 10; c++) begin
         if (c > 1) begin
            rst_n <= 1'b0;
            @(posedge clk);
         end
         rst_n <= 1'b1;
         lf = lfsr(lf);
         lat <= lf[1:0];
         wb(1'b1, media_cfg_pkg::WB_OPBASE, lf);
         wb(1'b1, media_cfg_pkg::WB_GPBASE, lfsr(lf) & ~32'h0800_0000);
         run(c[3:0]);
         eo = {2'b00, c < 5, c == 2 || c == 4 || c == 6};
         if (c == 3 || c == 4) eo[3:2] = 2'b11;
         ec = (c > 7) ? 32'h9 : (c > 4) ? 32'h1 : 32'h0;
         et = (c == 5) ? media_cfg_pkg::TXRX_TP_HD : (c == 6) ? media_cfg_pkg::TXRX_TP_FD :
              (c == 7) ? media_cfg_pkg::TXRX_AN : (c > 7) ? media_cfg_pkg::TXRX_AUI : 32'h0;
         nw = (c > 7) ? 8'h5 : 8'h4;
         chk({28'h0, op[24], op[23], op[18], op[9]}, {28'h0, eo});
         chk(conn, ec);
         chk(txrx, et);
         if (c > 7) chk({31'h0, gp[3]}, {31'h0, c == 8});
         chk({24'h0, nwr}, {24'h0, nw});
         run(4'h1);
         chk({31'h0, r[media_cfg_pkg::ST_REFUSED]}, 32'h1);
         chk({24'h0, nwr}, {24'h0, nw});
         chk({31'h0, r[media_cfg_pkg::ST_PORTDONE]}, 32'h1);
         wb(1'b1, media_cfg_pkg::WB_STATUS, 32'h4);
         wb(1'b0, media_cfg_pkg::WB_STATUS, 32'h0);
         chk({31'h0, r[media_cfg_pkg::ST_REFUSED]}, 32'h0);
         for (int g = 10; g < 14; g++) begin
            nw = nwr + 8'h2;
            run(g[3:0]);
            chk({30'h0, role}, g - 10);
            chk({16'h0, nwr, 7'h0, gp[27]}, {16'h0, nw, 8'h0});
         end
         $display("test %0d done", c);
      end
      end_of_test();
   end
endmodule : tb_top
